// ==== pcs_params.svh ====
// Register map, field positions and reset values of the PWM clock scale and pair-join block
// Summary of operation
// - Joined four-five runs 16-bit out pin five
// - Joined two-three runs 16-bit out pin three
// - Joined zero-one runs 16-bit out pin one
// - Joined pair uses lower channel's settings
// - Clear join bit keeps two independent channels
// - Wait-stop bit halts prescaler clock in wait
// - Freeze-stop bit halts prescaler clock in freeze
// - Registers stay accessible during freeze mode
// - Factory test location unavailable, reads zero
// - Clock A down counter pulses at one, reloads
// - Pulse stream halved gives scaled clock A
// - Scale zero counts as 256
// - Scaled clock B built the same way
// - Scale write reloads its down counter at once
// - Clock select bit picks plain or scaled
// - Scale A at 0x08, scale B at 0x09
// - Control register at offset 0x05
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// Register indices; byte address is four times the index
`define PCS_IDX_CTL      6'h05
`define PCS_IDX_TEST     6'h06
`define PCS_IDX_SCALE_A  6'h08
`define PCS_IDX_SCALE_B  6'h09
`define PCS_IDX_CLKSEL   6'h20
`define PCS_IDX_STATUS   6'h21

// Control register fields
`define PCS_CTL_JOIN_LSB    4
`define PCS_CTL_WAIT_BIT    3
`define PCS_CTL_FREEZE_BIT  2
`define PCS_CTL_MASK        8'h7C
`define PCS_CLKSEL_MASK     8'h3F

// Status register fields
`define PCS_STAT_RUN_BIT    0
`define PCS_STAT_PHASE_A    1
`define PCS_STAT_PHASE_B    2

// Reset values
`define PCS_CTL_RESET       8'h00
`define PCS_SCALE_RESET     8'h00
`define PCS_CLKSEL_RESET    8'h00

`endif

// ==== pcs_pkg.sv ====
// Types shared by the PWM clock scale and pair-join block
`default_nettype none
package pcs_pkg;

	// One register byte
	typedef logic [7:0] pcs_byte_t;

	// One bit per channel
	typedef logic [5:0] pcs_chan_t;

	// Bus slave answer sequence
	typedef enum logic {
		PCS_BUS_IDLE,
		PCS_BUS_ANSWER
	} pcs_bus_e;

endpackage : pcs_pkg
`default_nettype wire

// ==== pcs_scaler.sv ====
// Scaled clock generator: reloadable down counter followed by a divide by two
`timescale 1ns/1ps
`default_nettype none
module pcs_scaler #(
	parameter int WIDTH = 8                        // Down counter width
) (
	input  wire logic             clock_i,         // Bus clock
	input  wire logic             reset_i,         // Async reset, active high
	input  wire logic             tick_i,          // Input clock enable pulse
	input  wire logic             load_i,          // Scale register written
	input  wire logic [WIDTH-1:0] load_value_i,    // Value being written
	input  wire logic [WIDTH-1:0] scale_i,         // Current scale value
	output logic                  scaled_tick_o,   // Scaled clock enable pulse
	output logic                  phase_o          // Divide-by-two state
);

	logic [WIDTH-1:0] count_reg;                   // Down counter
	logic             phase_reg;                   // Divide-by-two flop
	logic             terminal;                    // Counter at one on a tick

	// A zero scale needs no special case: 0 wraps to all ones and counts the full range
	assign terminal = tick_i && (count_reg == WIDTH'(1));

	// Down counter; a write reloads at once so a new rate starts cleanly
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			count_reg <= '0;
		end else if (load_i) begin
			count_reg <= load_value_i;
		end else if (terminal) begin
			count_reg <= scale_i;
		end else if (tick_i) begin
			count_reg <= count_reg - WIDTH'(1);
		end
	end

	// Divide the terminal pulses by two
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			phase_reg <= 1'b0;
		end else if (terminal) begin
			phase_reg <= ~phase_reg;
		end
	end

	// One pulse per two terminal pulses, on the bus clock
	assign scaled_tick_o = terminal && phase_reg;
	assign phase_o       = phase_reg;

	a_reload_terminal: assert property (@(posedge clock_i) disable iff (reset_i)
		(terminal && !load_i) |=> (count_reg == $past(scale_i)))
		else $error("down counter did not reload at one");

	a_load_write: assert property (@(posedge clock_i) disable iff (reset_i)
		load_i |=> (count_reg == $past(load_value_i)))
		else $error("scale write did not reload counter");

	a_zero_wraps: assert property (@(posedge clock_i) disable iff (reset_i)
		(tick_i && !load_i && count_reg == '0) |=> (count_reg == {WIDTH{1'b1}}))
		else $error("zero scale did not count full range");

	a_half_rate: assert property (@(posedge clock_i) disable iff (reset_i)
		(terminal && !phase_reg) |-> !scaled_tick_o)
		else $error("scaled pulse on wrong phase");

endmodule : pcs_scaler
`default_nettype wire

// ==== pcs_pair_cfg.sv ====
// Per-pair clock selection, join mapping and output pin routing
`timescale 1ns/1ps
`default_nettype none
module pcs_pair_cfg (
	input  wire logic             clock_i,        // Bus clock
	input  wire logic             reset_i,        // Async reset, active high
	input  wire logic [2:0]       join_i,         // Pair join bits
	input  wire pcs_pkg::pcs_chan_t sel_i,        // Clock select bits
	input  wire pcs_pkg::pcs_chan_t polarity_i,   // Channel polarity bits
	input  wire pcs_pkg::pcs_chan_t enable_i,     // Channel enable bits
	input  wire pcs_pkg::pcs_chan_t center_i,     // Center-aligned bits
	input  wire pcs_pkg::pcs_chan_t wave_i,       // Channel waveforms
	input  wire logic             tick_a_i,       // Clock A enable
	input  wire logic             tick_sa_i,      // Scaled clock A enable
	input  wire logic             tick_b_i,       // Clock B enable
	input  wire logic             tick_sb_i,      // Scaled clock B enable
	output pcs_pkg::pcs_chan_t    chan_tick_o,    // Counting clock per channel
	output pcs_pkg::pcs_chan_t    eff_polarity_o, // Effective polarity
	output pcs_pkg::pcs_chan_t    eff_enable_o,   // Effective enable
	output pcs_pkg::pcs_chan_t    eff_center_o,   // Effective center mode
	output pcs_pkg::pcs_chan_t    pwm_output_port_o // Output pins
);
	import pcs_pkg::*;

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_pair
			localparam int HI = 2 * p;                   // Upper byte channel
			localparam int LO = 2 * p + 1;               // Lower byte channel
			logic plain;                                 // Plain clock of this pair
			logic scaled;                                // Scaled clock of this pair
			logic sel_hi;                                // Select used by upper channel

			// The middle pair runs from clock B, the outer pairs from clock A
			assign plain  = (p == 1) ? tick_b_i : tick_a_i;
			assign scaled = (p == 1) ? tick_sb_i : tick_sa_i;

			// A joined pair counts both bytes on the lower channel's clock
			assign sel_hi = join_i[p] ? sel_i[LO] : sel_i[HI];
			assign chan_tick_o[LO] = sel_i[LO] ? scaled : plain;
			assign chan_tick_o[HI] = sel_hi ? scaled : plain;

			// Settings and pins are registered; the upper pin is quiet when joined
			always_ff @(posedge clock_i or posedge reset_i) begin
				if (reset_i) begin
					eff_polarity_o[HI +: 2]    <= 2'b00;
					eff_enable_o[HI +: 2]      <= 2'b00;
					eff_center_o[HI +: 2]      <= 2'b00;
					pwm_output_port_o[HI +: 2] <= 2'b00;
				end else if (join_i[p]) begin
					eff_polarity_o[HI +: 2]    <= {2{polarity_i[LO]}};
					eff_enable_o[HI +: 2]      <= {2{enable_i[LO]}};
					eff_center_o[HI +: 2]      <= {2{center_i[LO]}};
					pwm_output_port_o[HI +: 2] <= {wave_i[LO] & enable_i[LO], 1'b0};
				end else begin
					eff_polarity_o[HI +: 2]    <= polarity_i[HI +: 2];
					eff_enable_o[HI +: 2]      <= enable_i[HI +: 2];
					eff_center_o[HI +: 2]      <= center_i[HI +: 2];
					pwm_output_port_o[HI +: 2] <= wave_i[HI +: 2] & enable_i[HI +: 2];
				end
			end

			a_upper_quiet: assert property (@(posedge clock_i) disable iff (reset_i)
				join_i[p] |=> !pwm_output_port_o[HI])
				else $error("upper pin driven while joined");
		end
	endgenerate

endmodule : pcs_pair_cfg
`default_nettype wire

// ==== pcs_top.sv ====
// Top of the PWM clock scale and pair-join block with its Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_top (
	input  wire logic               clock_i,          // Bus clock, 125 MHz
	input  wire logic               reset_i,          // Async reset, active high
	input  wire logic [7:0]         address_i,        // Avalon byte address
	input  wire logic               read_i,           // Avalon read
	input  wire logic               write_i,          // Avalon write
	input  wire logic [31:0]        writedata_i,      // Avalon write data
	input  wire logic [3:0]         byteenable_i,     // Avalon byte enables
	output logic [31:0]             readdata_o,       // Avalon read data
	output logic                    waitrequest_o,    // Avalon wait request
	input  wire logic               wait_mode_i,      // Processor in wait mode
	input  wire logic               freeze_mode_i,    // Processor in freeze mode
	input  wire logic               clock_a_tick_i,   // Clock A enable from prescaler
	input  wire logic               clock_b_tick_i,   // Clock B enable from prescaler
	input  wire pcs_pkg::pcs_chan_t polarity_i,       // Channel polarity bits
	input  wire pcs_pkg::pcs_chan_t enable_i,         // Channel enable bits
	input  wire pcs_pkg::pcs_chan_t center_i,         // Center-aligned bits
	input  wire pcs_pkg::pcs_chan_t wave_i,           // Channel waveforms
	output logic                    prescaler_run_o,  // Prescaler input clock allowed
	output logic [2:0]              join_o,           // Pair join bits to counters
	output pcs_pkg::pcs_chan_t      chan_tick_o,      // Counting clock per channel
	output pcs_pkg::pcs_chan_t      eff_polarity_o,   // Effective polarity
	output pcs_pkg::pcs_chan_t      eff_enable_o,     // Effective enable
	output pcs_pkg::pcs_chan_t      eff_center_o,     // Effective center mode
	output pcs_pkg::pcs_chan_t      pwm_output_port_o // Output pins
);
	import pcs_pkg::*;

	// Register file
	pcs_byte_t   ctl_reg;          // Join, wait-stop and freeze-stop bits
	pcs_byte_t   scale_a_reg;      // Scale A value
	pcs_byte_t   scale_b_reg;      // Scale B value
	pcs_byte_t   clksel_reg;       // Per-channel clock select bits
	logic [31:0] readdata_reg;     // Read data snapshot
	pcs_bus_e    bus_state_reg;    // Bus answer state
	pcs_bus_e    bus_state_next;   // Next bus answer state

	// Bus decode
	logic        bus_req;          // A request is on the bus
	logic        bus_take;         // Request completes at this edge
	logic        wr_lane;          // Write to the low byte lane completes
	logic        wr_ctl;           // Control register written
	logic        wr_scale_a;       // Scale A written
	logic        wr_scale_b;       // Scale B written
	logic        wr_clksel;        // Clock select written
	pcs_byte_t   read_value;       // Byte selected for reading

	// Clock path
	logic        tick_a;           // Clock A after gating
	logic        tick_b;           // Clock B after gating
	logic        tick_sa;          // Scaled clock A enable
	logic        tick_sb;          // Scaled clock B enable
	logic        phase_a;          // Scaled A divider state
	logic        phase_b;          // Scaled B divider state
	logic        wait_stop_bit;    // Wait-stop control
	logic        freeze_stop_bit;  // Freeze-stop control

	// Address hits only on an aligned word at the given index
	function automatic logic pcs_hit(input logic [7:0] addr, input logic [5:0] idx);
		pcs_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
	endfunction : pcs_hit

	// Bus answer: every request waits exactly one cycle, then completes
	assign bus_req       = read_i | write_i;
	assign bus_take      = bus_req && (bus_state_reg == PCS_BUS_ANSWER);
	assign waitrequest_o = bus_req && (bus_state_reg != PCS_BUS_ANSWER);

	// Next answer state
	always_comb begin
		bus_state_next = bus_state_reg;
		unique case (bus_state_reg)
			PCS_BUS_IDLE: begin
				if (bus_req) begin // Request seen, answer next cycle
					bus_state_next = PCS_BUS_ANSWER;
				end
			end
			PCS_BUS_ANSWER: begin
				bus_state_next = PCS_BUS_IDLE; // Completed, back to idle
			end
		endcase
	end

	// Answer state register; it never depends on the PWM modes, so freeze keeps the bus alive
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bus_state_reg <= PCS_BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	// Writes act only at the completing edge and only through the low byte lane
	assign wr_lane    = write_i && bus_take && byteenable_i[0];
	assign wr_ctl     = wr_lane && pcs_hit(address_i, `PCS_IDX_CTL);
	assign wr_scale_a = wr_lane && pcs_hit(address_i, `PCS_IDX_SCALE_A);
	assign wr_scale_b = wr_lane && pcs_hit(address_i, `PCS_IDX_SCALE_B);
	assign wr_clksel  = wr_lane && pcs_hit(address_i, `PCS_IDX_CLKSEL);

	// Control register; undescribed bits are held at zero
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ctl_reg <= `PCS_CTL_RESET;
		end else if (wr_ctl) begin
			ctl_reg <= writedata_i[7:0] & `PCS_CTL_MASK;
		end
	end

	// Scale A register
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			scale_a_reg <= `PCS_SCALE_RESET;
		end else if (wr_scale_a) begin
			scale_a_reg <= writedata_i[7:0];
		end
	end

	// Scale B register
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			scale_b_reg <= `PCS_SCALE_RESET;
		end else if (wr_scale_b) begin
			scale_b_reg <= writedata_i[7:0];
		end
	end

	// Clock select register, one bit per channel
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			clksel_reg <= `PCS_CLKSEL_RESET;
		end else if (wr_clksel) begin
			clksel_reg <= writedata_i[7:0] & `PCS_CLKSEL_MASK;
		end
	end

	// Read mux; the factory test location and unmapped words read as zero
	always_comb begin
		read_value = 8'h00;
		if (pcs_hit(address_i, `PCS_IDX_CTL)) begin
			read_value = ctl_reg;
		end else if (pcs_hit(address_i, `PCS_IDX_SCALE_A)) begin
			read_value = scale_a_reg;
		end else if (pcs_hit(address_i, `PCS_IDX_SCALE_B)) begin
			read_value = scale_b_reg;
		end else if (pcs_hit(address_i, `PCS_IDX_CLKSEL)) begin
			read_value = clksel_reg;
		end else if (pcs_hit(address_i, `PCS_IDX_STATUS)) begin
			read_value = {5'b0_0000, phase_b, phase_a, prescaler_run_o};
		end else if (pcs_hit(address_i, `PCS_IDX_TEST)) begin
			read_value = 8'h00;
		end
	end

	// Read data is caught when the request is first seen and held through completion
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			readdata_reg <= 32'h0000_0000;
		end else if (read_i && (bus_state_reg == PCS_BUS_IDLE)) begin
			readdata_reg <= {24'h00_0000, read_value};
		end
	end
	assign readdata_o = readdata_reg;

	// Mode gating of the prescaler input clock
	assign wait_stop_bit   = ctl_reg[`PCS_CTL_WAIT_BIT];
	assign freeze_stop_bit = ctl_reg[`PCS_CTL_FREEZE_BIT];
	assign prescaler_run_o = !(wait_mode_i && wait_stop_bit)
		&& !(freeze_mode_i && freeze_stop_bit);

	// Gate the clock enables here too, so a late prescaler pulse cannot advance the scalers
	assign tick_a = clock_a_tick_i && prescaler_run_o;
	assign tick_b = clock_b_tick_i && prescaler_run_o;
	assign join_o = ctl_reg[`PCS_CTL_JOIN_LSB +: 3];

	// Scaled clock A: the write data goes straight into the counter on a write
	pcs_scaler #(
		.WIDTH (8)
	) u_scaler_a (
		.clock_i       (clock_i),
		.reset_i       (reset_i),
		.tick_i        (tick_a),
		.load_i        (wr_scale_a),
		.load_value_i  (writedata_i[7:0]),
		.scale_i       (scale_a_reg),
		.scaled_tick_o (tick_sa),
		.phase_o       (phase_a)
	);

	// Scaled clock B, same structure on clock B
	pcs_scaler #(
		.WIDTH (8)
	) u_scaler_b (
		.clock_i       (clock_i),
		.reset_i       (reset_i),
		.tick_i        (tick_b),
		.load_i        (wr_scale_b),
		.load_value_i  (writedata_i[7:0]),
		.scale_i       (scale_b_reg),
		.scaled_tick_o (tick_sb),
		.phase_o       (phase_b)
	);

	// Channel clock choice, pair joining and pin routing
	pcs_pair_cfg u_pair_cfg (
		.clock_i           (clock_i),
		.reset_i           (reset_i),
		.join_i            (join_o),
		.sel_i             (clksel_reg[5:0]),
		.polarity_i        (polarity_i),
		.enable_i          (enable_i),
		.center_i          (center_i),
		.wave_i            (wave_i),
		.tick_a_i          (tick_a),
		.tick_sa_i         (tick_sa),
		.tick_b_i          (tick_b),
		.tick_sb_i         (tick_sb),
		.chan_tick_o       (chan_tick_o),
		.eff_polarity_o    (eff_polarity_o),
		.eff_enable_o      (eff_enable_o),
		.eff_center_o      (eff_center_o),
		.pwm_output_port_o (pwm_output_port_o)
	);

	// Steps of one bus access
	sequence s_first_seen;
		bus_req && (bus_state_reg == PCS_BUS_IDLE);
	endsequence

	sequence s_completes;
		bus_req && !waitrequest_o;
	endsequence

	a_bus_one_wait: assert property (@(posedge clock_i) disable iff (reset_i)
		s_first_seen |=> s_completes)
		else $error("bus request not answered after one wait cycle");

	a_ctl_write: assert property (@(posedge clock_i) disable iff (reset_i)
		wr_ctl |=> (ctl_reg == ($past(writedata_i[7:0]) & `PCS_CTL_MASK)))
		else $error("control write not stored");

	a_test_zero: assert property (@(posedge clock_i) disable iff (reset_i)
		(s_first_seen and (read_i && pcs_hit(address_i, `PCS_IDX_TEST))) |=> (readdata_o == 32'h0000_0000))
		else $error("factory test location did not read zero");

	a_scale_a_read: assert property (@(posedge clock_i) disable iff (reset_i)
		(s_first_seen and (read_i && pcs_hit(address_i, `PCS_IDX_SCALE_A)))
		|=> (readdata_o[7:0] == $past(scale_a_reg)))
		else $error("scale A read back wrong");

	a_wait_gate: assert property (@(posedge clock_i) disable iff (reset_i)
		(wait_mode_i && wait_stop_bit) |-> (!prescaler_run_o && !tick_a && !tick_b))
		else $error("prescaler clock ran in wait with wait-stop set");

	a_freeze_gate: assert property (@(posedge clock_i) disable iff (reset_i)
		(freeze_mode_i && freeze_stop_bit) |-> !prescaler_run_o)
		else $error("prescaler clock ran in freeze with freeze-stop set");

	a_run_free: assert property (@(posedge clock_i) disable iff (reset_i)
		(!(wait_mode_i && wait_stop_bit) && !freeze_mode_i) |-> prescaler_run_o)
		else $error("prescaler clock stopped without cause");

	a_freeze_resume: assert property (@(posedge clock_i) disable iff (reset_i)
		(freeze_mode_i && freeze_stop_bit && wr_ctl && !writedata_i[`PCS_CTL_FREEZE_BIT] && !wait_mode_i)
		|=> prescaler_run_o)
		else $error("clearing freeze-stop did not restart prescaler clock");

	a_joined_tick: assert property (@(posedge clock_i) disable iff (reset_i)
		join_o[0] |-> (chan_tick_o[0] == chan_tick_o[1]))
		else $error("joined pair counting on different clocks");

	a_joined_pin: assert property (@(posedge clock_i) disable iff (reset_i)
		join_o[0] |=> (pwm_output_port_o[1] == ($past(wave_i[1]) && $past(enable_i[1]))))
		else $error("joined pair not driven on lower pin");

	a_scaled_sel: assert property (@(posedge clock_i) disable iff (reset_i)
		(clksel_reg[2] && !join_o[1]) |-> (chan_tick_o[2] == tick_sb))
		else $error("channel two not on scaled clock B");

endmodule : pcs_top
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the PWM clock scale and pair-join block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pcs_pkg::*;
	logic        clock_i = 1'b0;                 // Bus clock
	logic        reset_i = 1'b1;                 // Reset, held at start
	logic        read_i = 1'b0, write_i = 1'b0;  // Avalon strobes
	logic [7:0]  address_i = 8'h00;              // Avalon byte address
	logic [31:0] writedata_i = 32'h0000_0000;    // Avalon write data
	logic [3:0]  byteenable_i = 4'h1;            // Only lane 0 carries data
	logic [31:0] readdata_o, rd_val;             // Read data and last taken value
	logic        waitrequest_o, prescaler_run_o; // Handshake and gate level
	logic        wait_mode_i = 1'b0, freeze_mode_i = 1'b0;
	logic        clock_a_tick_i = 1'b0, clock_b_tick_i = 1'b0;
	pcs_chan_t   polarity_i = 6'h2A, enable_i = 6'h3F, center_i = 6'h2A, wave_i = 6'h3F;
	logic [2:0]  join_o;                         // Join bits seen by counters
	pcs_chan_t   chan_tick_o, eff_polarity_o, eff_enable_o, eff_center_o, pwm_output_port_o;
	int          miscompares = 0, total_checks = 0, cycles = 0, n, pulses;
	logic [7:0]  adr [7] = '{8'h14, 8'h20, 8'h24, 8'h80, 8'h18, 8'h1C, 8'h21};
	logic [7:0]  msk [7] = '{8'h7C, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00};
	pcs_chan_t   e_pin, e_pol, e_en;             // Expected pins, polarity and enable

	// Free-running 125 MHz clock
	always #4 clock_i = ~clock_i;

	pcs_top i_dut (.clock_i(clock_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .wait_mode_i(wait_mode_i), .freeze_mode_i(freeze_mode_i),
		.clock_a_tick_i(clock_a_tick_i), .clock_b_tick_i(clock_b_tick_i), .polarity_i(polarity_i),
		.enable_i(enable_i), .center_i(center_i), .wave_i(wave_i), .prescaler_run_o(prescaler_run_o),
		.join_o(join_o), .chan_tick_o(chan_tick_o), .eff_polarity_o(eff_polarity_o),
		.eff_enable_o(eff_enable_o), .eff_center_o(eff_center_o), .pwm_output_port_o(pwm_output_port_o));

	// Compare and count; four-state equality so unknowns never match
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One Avalon access; opens with an edge so back-to-back calls never drive twice in one step
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		address_i <= a;
		writedata_i <= {24'h00_0000, d};
		read_i <= !wr;
		write_i <= wr;
		do @(posedge clock_i); while (waitrequest_o !== 1'b0);
		rd_val = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask : bus

	// Reset values, writable bits, reserved and unmapped places
	task t_regs;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, adr[i], 8'h00);
			check(rd_val, 32'h0000_0000);
			bus(1'b1, adr[i], 8'hFF);
			bus(1'b0, adr[i], 8'h00);
			check(rd_val, {24'h00_0000, msk[i]});
			bus(1'b1, adr[i], 8'h00);
		end
	endtask : t_regs

	// Every mix of stop bits and processor modes; registers stay reachable meanwhile
	task t_gate;
		for (n = 0; n < 16; n++) begin
			bus(1'b1, 8'h14, {4'h0, n[1:0], 2'b00});
			wait_mode_i <= n[2];
			freeze_mode_i <= n[3];
			bus(1'b0, 8'h14, 8'h00);
			check(rd_val, {28'h000_0000, n[1:0], 2'b00});
			check(prescaler_run_o, !((n[2] && n[1]) || (n[3] && n[0])));
			bus(1'b0, 8'h84, 8'h00);
			check(rd_val, {31'h0000_0000, !((n[2] && n[1]) || (n[3] && n[0]))});
		end
		wait_mode_i <= 1'b0;
		freeze_mode_i <= 1'b0;
		bus(1'b1, 8'h14, 8'h00);
	endtask : t_gate

	// Write a scale, feed ticks back to back, count scaled pulses; odd channel stays plain
	task t_scale(input logic b, input logic [7:0] scale, input int ticks, input int exp);
		bus(1'b1, b ? 8'h24 : 8'h20, scale);
		bus(1'b1, 8'h80, 8'h05);
		pulses = 0;
		for (int i = 0; i < ticks; i++) begin
			@(posedge clock_i);
			clock_a_tick_i <= !b;
			clock_b_tick_i <= b;
			@(negedge clock_i);
			pulses += chan_tick_o[b ? 2 : 0];
			check(chan_tick_o[b ? 3 : 1], 1'b1);
		end
		@(posedge clock_i);
		clock_a_tick_i <= 1'b0;
		clock_b_tick_i <= 1'b0;
		check(pulses, exp);
	endtask : t_scale

	// All join codes: pin routing and lower channel settings
	task t_join;
		// Even channels of the upper pairs disabled, so a joined pair must copy the odd enable
		enable_i <= 6'h2B;
		for (n = 0; n < 8; n++) begin
			bus(1'b1, 8'h14, {1'b0, n[2:0], 4'h0});
			repeat (2) @(posedge clock_i);
			e_pin = 6'h2B;
			e_pol = 6'h2A;
			e_en = 6'h2B;
			for (int p = 0; p < 3; p++) begin
				// Joined pair: even pin idle, even settings mirror the odd channel
				if (n[p]) begin
					e_pin[2 * p] = 1'b0;
					e_pol[2 * p] = 1'b1;
					e_en[2 * p] = 1'b1;
				end
			end
			check(join_o, n[2:0]);
			check(pwm_output_port_o, e_pin);
			check(eff_polarity_o, e_pol);
			check(eff_center_o, e_pol);
			check(eff_enable_o, e_en);
		end
	endtask : t_join

	// Report counts and verdict, then stop
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	// Hang guard well above the roughly 1400 cycles the run needs
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		t_regs();
		t_gate();
		t_scale(1'b0, 8'd200, 4, 0);
		t_scale(1'b0, 8'h01, 4, 2);
		t_scale(1'b0, 8'h03, 12, 2);
		t_scale(1'b1, 8'h02, 8, 2);
		t_scale(1'b0, 8'h00, 1024, 2);
		t_join();
		test_done();
	end
endmodule : tb
`default_nettype wire
